// File: hdl/atd_pkg.sv
// Constants and types of the accelerator task dispatcher
package atd_pkg;
  localparam int NUM_TASKS = 8;
  localparam int ID_W = 3;
  localparam logic [2:0] BG_SLOT = 3'h7;
  localparam logic [7:0] FG_MASK = 8'h7f;
  localparam logic [15:0] ENTRY_BASE = 16'h0000;
  localparam int ENTRY_SHIFT = 6;
  localparam logic [9:0] FP_BIAS = 10'h07f;
  localparam logic [7:0] FP_EXP_MAX = 8'hff;
  localparam logic [7:0] PEND_RST = 8'h00;

  typedef enum logic [1:0] {
    ATD_IDLE = 2'b00,
    ATD_RUN = 2'b01,
    ATD_BG = 2'b11,
    ATD_PRE = 2'b10
  } atd_state_t;

  typedef struct packed {
    atd_state_t st;
    logic [2:0] id;
    logic start;
    logic resume;
    logic run;
    logic bg_act;
    logic bg_saved;
    logic [15:0] addr;
    logic [31:0] conv;
    logic [31:0] prod;
  } atd_core_t;

  localparam atd_core_t CORE_RST = '{st: ATD_IDLE, id: 3'h0, start: 1'b0, resume: 1'b0, run: 1'b0,
                                     bg_act: 1'b0, bg_saved: 1'b0, addr: 16'h0000, conv: 32'h0000_0000,
                                     prod: 32'h0000_0000};
endpackage : atd_pkg

// File: hdl/atd_pend_flag.sv
// One sticky pending flag of a task slot
`timescale 1ns/1ns
module atd_pend_flag (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic set_i,
  input wire logic clr_i,
  output logic pend_o
);
  typedef struct packed {
    logic pend;
  } atd_flag_t;

  atd_flag_t flag_q;
  atd_flag_t flag_d;

  always_comb begin
    flag_d = flag_q;
    // A trigger in the dispatch cycle survives the clear
    if (set_i) begin
      flag_d.pend = 1'b1;
    end else if (clr_i) begin
      flag_d.pend = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flag_q <= '{pend: 1'b0};
    end else begin
      flag_q <= flag_d;
    end
  end

  assign pend_o = flag_q.pend;

  a_pend_set: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) set_i |=> pend_o)
    else $error("pending flag lost a trigger");
endmodule : atd_pend_flag

// File: hdl/atd_dispatch.sv
// Task dispatcher of the control-loop accelerator
`timescale 1ns/1ns
module atd_dispatch (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] trig_i,
  input wire logic [7:0] trig_en_i,
  input wire logic bg_mode_i,
  input wire logic task_done_i,
  input wire logic core_term_i,
  input wire logic host_term_i,
  input wire logic bg_atomic_i,
  input wire logic conv_done_i,
  input wire logic [31:0] conv_data_i,
  input wire logic [31:0] mul_a_i,
  input wire logic [31:0] mul_b_i,
  output logic [7:0] pend_o,
  output logic start_o,
  output logic resume_o,
  output logic run_o,
  output logic bg_active_o,
  output logic [2:0] task_id_o,
  output logic [15:0] task_addr_o,
  output logic [31:0] conv_result_o,
  output logic [31:0] mul_p_o
);
  atd_pkg::atd_core_t core_q;
  atd_pkg::atd_core_t core_d;
  logic [7:0] clr;
  logic [7:0] fg_pend;
  logic [3:0] pick_all;
  logic [3:0] pick_fg;
  logic bg_stop;

  // Lowest-numbered pending slot has top priority; bit 3 flags any pending
  function automatic logic [3:0] pick_lowest(input logic [7:0] vec);
    logic [3:0] res;
    res = 4'h0;
    for (int i = atd_pkg::NUM_TASKS - 1; i >= 0; i--) begin
      if (vec[i]) begin
        res = {1'b1, i[2:0]};
      end
    end
    return res;
  endfunction : pick_lowest

  // Single-cycle IEEE single-precision multiply, truncating, denormals flushed to zero
  function automatic logic [31:0] fmul(input logic [31:0] a, input logic [31:0] b);
    logic sgn;
    logic [47:0] mp;
    logic [9:0] ex;
    logic [22:0] man;
    logic [31:0] res;
    sgn = a[31] ^ b[31];
    mp = {1'b1, a[22:0]} * {1'b1, b[22:0]};
    ex = {2'b00, a[30:23]} + {2'b00, b[30:23]} - atd_pkg::FP_BIAS;
    if (mp[47]) begin
      man = mp[46:24];
      ex = ex + 10'h001;
    end else begin
      man = mp[45:23];
    end
    if (a[30:23] == 8'h00 || b[30:23] == 8'h00 || ex[9] || ex == 10'h000) begin
      res = {sgn, 31'h0000_0000};
    end else if (ex[8] || ex[7:0] == atd_pkg::FP_EXP_MAX) begin
      res = {sgn, atd_pkg::FP_EXP_MAX, 23'h000000};
    end else begin
      res = {sgn, ex[7:0], man};
    end
    return res;
  endfunction : fmul

  function automatic logic [15:0] entry_of(input logic [2:0] id);
    return atd_pkg::ENTRY_BASE + (16'({13'h0000, id}) << atd_pkg::ENTRY_SHIFT);
  endfunction : entry_of

  genvar g;
  generate
    for (g = 0; g < atd_pkg::NUM_TASKS; g++) begin : g_pend
      atd_pend_flag u_flag (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .set_i(trig_i[g] & trig_en_i[g]),
        .clr_i(clr[g]),
        .pend_o(pend_o[g])
      );
    end
  endgenerate

  assign fg_pend = pend_o & atd_pkg::FG_MASK;
  assign pick_all = pick_lowest(pend_o);
  assign pick_fg = pick_lowest(fg_pend);
  assign bg_stop = core_term_i | host_term_i;

  always_comb begin
    core_d = core_q;
    core_d.start = 1'b0;
    core_d.resume = 1'b0;
    clr = 8'h00;
    case (core_q.st)
      atd_pkg::ATD_IDLE: begin
        // Dispatch straight from the trigger, host not involved
        if (pick_all[3]) begin
          core_d.id = pick_all[2:0];
          core_d.addr = entry_of(pick_all[2:0]);
          core_d.start = 1'b1;
          core_d.bg_saved = 1'b0;
          clr[pick_all[2:0]] = 1'b1;
          if (bg_mode_i && pick_all[2:0] == atd_pkg::BG_SLOT) begin
            core_d.st = atd_pkg::ATD_BG;
          end else begin
            core_d.st = atd_pkg::ATD_RUN;
          end
        end
      end
      atd_pkg::ATD_RUN: begin
        // Nothing else is dispatched until the running task ends
        if (task_done_i) begin
          core_d.st = atd_pkg::ATD_IDLE;
        end
      end
      atd_pkg::ATD_BG: begin
        if (bg_stop) begin
          core_d.st = atd_pkg::ATD_IDLE;
        end else if (pick_fg[3] && !bg_atomic_i) begin
          core_d.bg_saved = 1'b1;
          core_d.id = pick_fg[2:0];
          core_d.addr = entry_of(pick_fg[2:0]);
          core_d.start = 1'b1;
          clr[pick_fg[2:0]] = 1'b1;
          core_d.st = atd_pkg::ATD_PRE;
        end
      end
      atd_pkg::ATD_PRE: begin
        if (host_term_i) begin
          core_d.bg_saved = 1'b0;
        end
        if (task_done_i) begin
          if (pick_fg[3]) begin
            core_d.id = pick_fg[2:0];
            core_d.addr = entry_of(pick_fg[2:0]);
            core_d.start = 1'b1;
            clr[pick_fg[2:0]] = 1'b1;
          end else if (core_q.bg_saved && !host_term_i) begin
            core_d.id = atd_pkg::BG_SLOT;
            core_d.addr = entry_of(atd_pkg::BG_SLOT);
            core_d.resume = 1'b1;
            core_d.bg_saved = 1'b0;
            core_d.st = atd_pkg::ATD_BG;
          end else begin
            core_d.bg_saved = 1'b0;
            core_d.st = atd_pkg::ATD_IDLE;
          end
        end
      end
      default: begin
        core_d = atd_pkg::CORE_RST;
      end
    endcase
    core_d.run = (core_d.st != atd_pkg::ATD_IDLE);
    core_d.bg_act = (core_d.st == atd_pkg::ATD_BG);
    // Result latched at the completion edge, no host read in between
    if (conv_done_i) begin
      core_d.conv = conv_data_i;
    end
    core_d.prod = fmul(mul_a_i, mul_b_i);
  end

  // Own clock and state, host core never waits on this block
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      core_q <= atd_pkg::CORE_RST;
    end else begin
      core_q <= core_d;
    end
  end

  assign start_o = core_q.start;
  assign resume_o = core_q.resume;
  assign run_o = core_q.run;
  assign bg_active_o = core_q.bg_act;
  assign task_id_o = core_q.id;
  assign task_addr_o = core_q.addr;
  assign conv_result_o = core_q.conv;
  assign mul_p_o = core_q.prod;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  a_prio_lowest: assert property (start_o |-> (($past(pend_o) & ((8'h01 << task_id_o) - 8'h01)) == 8'h00))
    else $error("dispatched slot was not the highest priority");
  a_run_complete: assert property ((core_q.st == atd_pkg::ATD_RUN && !task_done_i) |=>
                                   (core_q.st == atd_pkg::ATD_RUN && $stable(task_id_o) && !start_o))
    else $error("normal task left before completion");
  a_bg_preempt: assert property ((core_q.st == atd_pkg::ATD_BG && fg_pend != 8'h00 && !bg_atomic_i && !bg_stop) |=>
                                 (core_q.st == atd_pkg::ATD_PRE && start_o && task_id_o != atd_pkg::BG_SLOT))
    else $error("background not preempted by pending task");
  a_bg_atomic: assert property ((core_q.st == atd_pkg::ATD_BG && bg_atomic_i) |=> !start_o)
    else $error("uninterruptible section was preempted");
  a_bg_resume: assert property ((core_q.st == atd_pkg::ATD_PRE && task_done_i && fg_pend == 8'h00 &&
                                 core_q.bg_saved && !host_term_i) |=>
                                (resume_o && bg_active_o && task_id_o == atd_pkg::BG_SLOT) ##1 !resume_o)
    else $error("background not resumed after preemption");
  a_bg_term: assert property ((core_q.st == atd_pkg::ATD_BG && bg_stop) |=> (!run_o && !bg_active_o))
    else $error("background not terminated");
  // Only a quiet dispatcher gives the fixed two-cycle start latency
  a_trig_start: assert property ((trig_i[0] && trig_en_i[0] && !run_o && pend_o == 8'h00) |->
                                 ##2 (start_o && task_id_o == 3'h0))
    else $error("trigger did not start its task");
  a_conv_same: assert property (conv_done_i |=> conv_result_o == $past(conv_data_i))
    else $error("converter result not captured at completion");
  a_bg_select: assert property ((start_o && task_id_o == atd_pkg::BG_SLOT && $past(core_q.st) == atd_pkg::ATD_IDLE)
                                |-> (bg_active_o == $past(bg_mode_i)))
    else $error("background option not applied to lowest slot");
  a_bg_mode_off: assert property ((core_q.st == atd_pkg::ATD_IDLE && !bg_mode_i) |=> !bg_active_o)
    else $error("background entered with option off");
  a_start_run: assert property (start_o |-> run_o)
    else $error("task started without running");

  c_normal_run: cover property (start_o && !bg_active_o ##[1:20] core_q.st == atd_pkg::ATD_IDLE);
  c_preempt: cover property (bg_active_o ##1 (start_o && core_q.st == atd_pkg::ATD_PRE));
  c_resume: cover property (resume_o);
  c_atomic_defer: cover property (bg_active_o && bg_atomic_i && fg_pend != 8'h00);
endmodule : atd_dispatch

// File: tb/atd_core_model.sv
// Behavioural accelerator core that ends each started foreground task
`timescale 1ns/1ns
module atd_core_model (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic start_i,
  input wire logic bg_i,
  input wire logic [3:0] len_i,
  output logic done_o
);
  logic [3:0] cnt_q;

  // Background starts never load the counter, so only foreground tasks finish
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= 4'h0;
      done_o <= 1'b0;
    end else begin
      done_o <= (cnt_q == 4'h1);
      if (start_i && !bg_i) begin
        cnt_q <= len_i;
      end else if (cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule : atd_core_model

// File: tb/atd_dispatch_tb.sv
// Self-checking bench for the accelerator task dispatcher
`timescale 1ns/1ns
module atd_dispatch_tb;
  logic sys_clk_i, rst_b_i, bg_mode_i, task_done_i, core_term_i, host_term_i, bg_atomic_i, conv_done_i;
  logic [7:0] trig_i, trig_en_i, pend_o;
  logic [31:0] conv_data_i, mul_a_i, mul_b_i, conv_result_o, mul_p_o;
  logic start_o, resume_o, run_o, bg_active_o;
  logic [2:0] task_id_o;
  logic [15:0] task_addr_o;
  int error_cnt = 0;
  int checks_done = 0;
  int lat;

  atd_dispatch dut_u (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .trig_i(trig_i), .trig_en_i(trig_en_i),
    .bg_mode_i(bg_mode_i), .task_done_i(task_done_i), .core_term_i(core_term_i), .host_term_i(host_term_i),
    .bg_atomic_i(bg_atomic_i), .conv_done_i(conv_done_i), .conv_data_i(conv_data_i), .mul_a_i(mul_a_i),
    .mul_b_i(mul_b_i), .pend_o(pend_o), .start_o(start_o), .resume_o(resume_o), .run_o(run_o),
    .bg_active_o(bg_active_o), .task_id_o(task_id_o), .task_addr_o(task_addr_o),
    .conv_result_o(conv_result_o), .mul_p_o(mul_p_o));
  atd_core_model core_u (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .start_i(start_o), .bg_i(bg_active_o),
    .len_i(4'h4), .done_o(task_done_i));

  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  task automatic give_verdict();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  task automatic tick(input int n = 1);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : tick

  task automatic chk(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : chk

  task automatic fire(input logic [7:0] m);
    trig_i = m;
    tick();
    trig_i = 8'h00;
  endtask : fire

  // Kind 0 waits for a start, 1 for a resume, 2 for idle; id is checked for 0 and 1
  task automatic wait_for(input int kind, input logic [2:0] id);
    logic hit;
    for (lat = 0; lat < 40; lat++) begin
      tick();
      hit = (kind == 0) ? start_o : (kind == 1) ? resume_o : !run_o;
      if (hit === 1'b1) break;
    end
    if (lat == 40) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: wait ran out", $time);
      give_verdict();
    end else if (kind != 2) begin
      chk(task_id_o === id && task_addr_o === {7'h00, id, 6'h00}, "task id or entry");
    end
  endtask : wait_for

  task automatic s_normal();
    fire(8'h04);
    chk(pend_o === 8'h04, "pending flag not set");
    wait_for(0, 3'h2);
    chk(lat == 0 && run_o === 1'b1 && pend_o === 8'h00, "start latency or run");
    wait_for(2, 3'h0);
    // Slot 7 without the background option is an ordinary task
    fire(8'h81);
    wait_for(0, 3'h0);
    chk(lat == 0 && pend_o === 8'h80, "slot 0 not first");
    wait_for(0, 3'h7);
    chk(bg_active_o === 1'b0 && run_o === 1'b1, "slot 7 ran as background without option");
    wait_for(2, 3'h0);
  endtask : s_normal

  task automatic s_prio();
    trig_en_i = 8'hef;
    fire(8'h20);
    wait_for(0, 3'h5);
    fire(8'h58);
    chk(pend_o === 8'h48 && task_id_o === 3'h5, "refusal or preemption of normal task");
    wait_for(0, 3'h3);
    wait_for(0, 3'h6);
    wait_for(2, 3'h0);
    chk(pend_o === 8'h00, "disabled slot became pending");
    trig_en_i = 8'hff;
  endtask : s_prio

  task automatic s_bg();
    bg_mode_i = 1'b1;
    fire(8'h80);
    wait_for(0, 3'h7);
    tick(6);
    chk(run_o === 1'b1 && bg_active_o === 1'b1, "background stopped");
    fire(8'h06);
    wait_for(0, 3'h1);
    chk(lat == 0 && bg_active_o === 1'b0, "preemption");
    wait_for(0, 3'h2);
    chk(bg_active_o === 1'b0 && pend_o === 8'h00, "second pending task not chained");
    wait_for(1, 3'h7);
    chk(bg_active_o === 1'b1, "background not resumed");
    bg_atomic_i = 1'b1;
    fire(8'h04);
    tick(5);
    chk(bg_active_o === 1'b1 && pend_o === 8'h04, "atomic section interrupted");
    bg_atomic_i = 1'b0;
    wait_for(0, 3'h2);
    wait_for(1, 3'h7);
    core_term_i = 1'b1;
    tick();
    core_term_i = 1'b0;
    tick();
    chk(run_o === 1'b0 && bg_active_o === 1'b0, "core end of background");
    fire(8'h80);
    wait_for(0, 3'h7);
    host_term_i = 1'b1;
    tick();
    host_term_i = 1'b0;
    tick();
    chk(run_o === 1'b0 && bg_active_o === 1'b0, "host end of background");
    // Host end while preempted drops the saved background
    fire(8'h80);
    wait_for(0, 3'h7);
    fire(8'h02);
    wait_for(0, 3'h1);
    host_term_i = 1'b1;
    tick();
    host_term_i = 1'b0;
    wait_for(2, 3'h0);
    chk(task_id_o === 3'h1 && resume_o === 1'b0, "host end during preemption not kept");
    bg_mode_i = 1'b0;
  endtask : s_bg

  task automatic s_math();
    conv_data_i = 32'h3f80_0000;
    conv_done_i = 1'b1;
    mul_a_i = 32'h4000_0000;
    mul_b_i = 32'h4040_0000;
    tick();
    conv_done_i = 1'b0;
    conv_data_i = 32'h0000_0000;
    mul_a_i = 32'hbfc0_0000;
    mul_b_i = 32'h4080_0000;
    chk(conv_result_o === 32'h3f80_0000, "conversion not taken in its cycle");
    chk(mul_p_o === 32'h40c0_0000, "first product");
    tick();
    chk(mul_p_o === 32'hc0c0_0000 && conv_result_o === 32'h3f80_0000, "back-to-back product");
  endtask : s_math

  initial begin
    rst_b_i = 1'b0;
    trig_i = 8'h00;
    trig_en_i = 8'hff;
    {bg_mode_i, core_term_i, host_term_i, bg_atomic_i, conv_done_i} = 5'h00;
    conv_data_i = 32'h0000_0000;
    mul_a_i = 32'h0000_0000;
    mul_b_i = 32'h0000_0000;
    tick(4);
    rst_b_i = 1'b1;
    chk(run_o === 1'b0 && pend_o === 8'h00, "reset state");
    s_normal();
    s_prio();
    s_bg();
    s_math();
    give_verdict();
  end
endmodule : atd_dispatch_tb
